// file: eitf_bench.sv
// eitf_bench: self-checking bench for the interrupt and timer 0 flag block.
// assumes the apb slave answers in time and the cpu model vectors on request.
`timescale 1ns/1ps
module eitf_bench;
   typedef struct packed {
      logic [1:0] pol;
      logic [1:0] typ;
      logic [1:0] pin;
      logic [1:0] exp_set;
      logic [1:0] exp_clr;
   } eitf_row_t;
   // ext1 in the upper bit of each pair
   localparam eitf_row_t ROWS [5] = '{
      '{2'h0, 2'h0, 2'h0, 2'h3, 2'h3},
      '{2'h3, 2'h3, 2'h3, 2'h3, 2'h0},
      '{2'h2, 2'h2, 2'h2, 2'h3, 2'h1},
      '{2'h1, 2'h1, 2'h1, 2'h3, 2'h2},
      '{2'h0, 2'h3, 2'h3, 2'h0, 2'h0}};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   eitf_pkg::eitf_apb_req_t req = '0;
   eitf_pkg::eitf_apb_rsp_t rsp;
   logic ext0 = 1'b1;
   logic ext1 = 1'b1;
   logic t0_ovf = 1'b0;
   logic [2:0] ack_en = 3'h0;
   logic [2:0] vec;
   logic f0, f1, ft0, cnt_en, irq;
   logic [31:0] rd;
   logic err;
   eitf_row_t r;
   int miscompares = 0;
   int tests_run = 0;

   eitf_top dut (.ref_clk_i(ref_clk), .rst_i(rst), .apb_req_i(req), .apb_rsp_o(rsp), .ext0_input_i(ext0),
      .ext1_input_i(ext1), .t0_overflow_i(t0_ovf), .vec_ext0_i(vec[0]), .vec_ext1_i(vec[1]), .vec_t0_i(vec[2]),
      .ext0_pending_flag_o(f0), .ext1_pending_flag_o(f1), .t0_overflow_flag_o(ft0), .t0_count_en_o(cnt_en),
      .irq_o(irq));
   eitf_cpu_model cpu (.ref_clk_i(ref_clk), .rst_i(rst), .ack_en_i(ack_en), .flag_i({ft0, f1, f0}), .vec_o(vec));

   // 10 MHz clock
   initial
   begin
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // one apb transfer; waits on pready, giving up after 20 cycles
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge ref_clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
      @(posedge ref_clk);
      req.penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 20);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
      check("pready", rsp.pready, 32'h1);
   endtask : apb

   task automatic rdchk(input string name, input logic [7:0] addr, input logic [31:0] exp);
      apb(1'b0, addr, 32'h0);
      check(name, rd, exp);
   endtask : rdchk

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cycles

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      #(20000 * 100);
      miscompares++;
      wrap_up();
   end

   initial
   begin
      cycles(12);
      rst <= 1'b0;
      @(posedge ref_clk);
      // reset values and an unmapped slot
      check("outputs after reset", {f0, f1, ft0, cnt_en, irq}, 32'h0);
      rdchk("ctrl reset", eitf_pkg::CTRL_OFS, 32'h0);
      rdchk("cfg reset", eitf_pkg::CFG_OFS, 32'h0);
      rdchk("mask reset", eitf_pkg::IRQ_MASK_OFS, 32'h0);
      apb(1'b1, 8'h10, 32'hffff_ffff);
      check("unmapped error", err, 32'h1);
      rdchk("unmapped read", 8'h10, 32'h0);
      // table: polarity, type and pin level against the flags
      for (int i = 0; i < 5; i++)
      begin
         r = ROWS[i];
         {ext1, ext0} <= ~r.pol;
         apb(1'b1, eitf_pkg::CFG_OFS, {30'h0, r.pol});
         apb(1'b1, eitf_pkg::CTRL_OFS, {29'h0, r.typ[1], 1'b0, r.typ[0]});
         {ext1, ext0} <= r.pin;
         cycles(3);
         check("flag pins", {f1, f0}, r.exp_set);
         rdchk("flags set", eitf_pkg::CTRL_OFS, {28'h0, r.exp_set[1], r.typ[1], r.exp_set[0], r.typ[0]});
         apb(1'b1, eitf_pkg::CTRL_OFS, {29'h0, r.typ[1], 1'b0, r.typ[0]});
         rdchk("flags cleared", eitf_pkg::CTRL_OFS, {28'h0, r.exp_clr[1], r.typ[1], r.exp_clr[0], r.typ[0]});
      end
      // edge mode: cleared by vectoring; level mode: vectoring ignored
      {ext1, ext0} <= 2'h0;
      ack_en <= 3'h3;
      apb(1'b1, eitf_pkg::CFG_OFS, 32'h3);
      apb(1'b1, eitf_pkg::CTRL_OFS, 32'h5);
      {ext1, ext0} <= 2'h3;
      cycles(2);
      check("edge flags", {f1, f0}, 32'h3);
      cycles(3);
      check("edge flags vectored", {f1, f0}, 32'h0);
      apb(1'b1, eitf_pkg::CTRL_OFS, 32'h0);
      cycles(4);
      check("level flags vectored", {f1, f0}, 32'h3);
      ack_en <= 3'h0;
      {ext1, ext0} <= 2'h0;
      apb(1'b1, eitf_pkg::CTRL_OFS, 32'h0);
      // timer 0 overflow: software clear, then vectoring clear
      for (int k = 0; k < 2; k++)
      begin
         ack_en <= {k[0], 2'h0};
         t0_ovf <= 1'b1;
         @(posedge ref_clk);
         t0_ovf <= 1'b0;
         cycles(1);
         check("t0 flag set", ft0, 32'h1);
         if (k == 0)
         begin
            rdchk("t0 flag bit", eitf_pkg::CTRL_OFS, 32'h20);
            apb(1'b1, eitf_pkg::CTRL_OFS, 32'h0);
         end
         cycles(3);
         check("t0 flag cleared", ft0, 32'h0);
      end
      ack_en <= 3'h0;
      // run bit with and without gate control
      apb(1'b1, eitf_pkg::CTRL_OFS, 32'h10);
      cycles(3);
      check("run no gate", cnt_en, 32'h1);
      apb(1'b1, eitf_pkg::CFG_OFS, 32'h7);
      cycles(3);
      check("run gated idle", cnt_en, 32'h0);
      ext0 <= 1'b1;
      cycles(3);
      check("run gated active", cnt_en, 32'h1);
      apb(1'b1, eitf_pkg::CTRL_OFS, 32'h0);
      cycles(3);
      check("run off", cnt_en, 32'h0);
      ext0 <= 1'b0;
      // interrupt status, mask and write-one-to-clear
      rdchk("status all", eitf_pkg::IRQ_STAT_OFS, 32'h7);
      check("irq masked", irq, 32'h0);
      apb(1'b1, eitf_pkg::IRQ_MASK_OFS, 32'h2);
      cycles(2);
      check("irq unmasked", irq, 32'h1);
      apb(1'b1, eitf_pkg::IRQ_STAT_OFS, 32'h2);
      cycles(2);
      check("irq after clear", irq, 32'h0);
      rdchk("status left", eitf_pkg::IRQ_STAT_OFS, 32'h5);
      apb(1'b1, eitf_pkg::IRQ_MASK_OFS, 32'h5);
      cycles(2);
      check("irq t0 ext0", irq, 32'h1);
      apb(1'b1, eitf_pkg::IRQ_STAT_OFS, 32'h5);
      cycles(2);
      check("irq all clear", irq, 32'h0);
      // mid-run reset with both external flags, mask bits 0 and 2 and all configuration bits set
      {ext1, ext0} <= 2'h3;
      cycles(2);
      check("flags before reset", {f1, f0}, 32'h3);
      rst <= 1'b1;
      cycles(3);
      rst <= 1'b0;
      cycles(2);
      // pins stay high, which is the inactive level once polarity is back at zero
      check("outputs after mid reset", {f0, f1, ft0, cnt_en, irq}, 32'h0);
      rdchk("cfg after mid reset", eitf_pkg::CFG_OFS, 32'h0);
      rdchk("mask after mid reset", eitf_pkg::IRQ_MASK_OFS, 32'h0);
      rdchk("status after mid reset", eitf_pkg::IRQ_STAT_OFS, 32'h0);
      rdchk("ctrl after mid reset", eitf_pkg::CTRL_OFS, 32'h0);
      wrap_up();
   end
endmodule : eitf_bench

// file: eitf_cpu_model.sv
// eitf_cpu_model: stands in for the cpu vectoring logic beside the flag block.
// assumes one clock; it only enters a handler whose bit the bench enables.
`timescale 1ns/1ps
module eitf_cpu_model
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // enabled handlers and pending flags, t0 ext1 ext0
   input wire logic [2:0] ack_en_i,
   input wire logic [2:0] flag_i,
   // one-cycle vectoring pulses
   output logic [2:0] vec_o
);
   logic [2:0] vec_q;
   // gap after each pulse, so a flag that stays set is not hammered every cycle
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         vec_q <= 3'h0;
      else
         vec_q <= flag_i & ack_en_i & ~vec_q;
   end
   assign vec_o = vec_q;
endmodule : eitf_cpu_model

// file: eitf_ext_chan.sv
// eitf_ext_chan: polarity correction and edge detection for one external input.
// assumes the pin is already synchronous to ref_clk_i.
`timescale 1ns/1ps
module eitf_ext_chan
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // pin and its configured sense
   input wire logic pin_i,
   input wire logic polarity_i,
   // corrected level and edge pulse
   output eitf_pkg::eitf_chan_t chan_o
);

   eitf_pkg::eitf_chan_state_t st_q;
   eitf_pkg::eitf_chan_state_t st_d;
   logic active;

   // polarity 1 means active high, 0 active low
   assign active = polarity_i ? pin_i : ~pin_i;
   // one driver for the whole carrier, level and edge pulse together
   // a polarity flip can itself look like an edge; software should set polarity before edge mode
   assign chan_o = '{active: active, edge_ev: active & ~st_q.active};

   // next state
   always_comb
   begin
      st_d = st_q;
      st_d.active = active;
   end

   // state register
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

endmodule : eitf_ext_chan

// file: eitf_pkg.sv
// eitf_pkg: constants and carrier types for the external interrupt and timer 0 flag block.
// assumes a 32-bit APB master and a single 10 MHz system clock.
package eitf_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CFG_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

   // control register field positions
   localparam int unsigned CTRL_T0_OVF = 5;
   localparam int unsigned CTRL_T0_RUN = 4;
   localparam int unsigned CTRL_EXT1_FLAG = 3;
   localparam int unsigned CTRL_EXT1_TYPE = 2;
   localparam int unsigned CTRL_EXT0_FLAG = 1;
   localparam int unsigned CTRL_EXT0_TYPE = 0;

   // configuration register field positions
   localparam int unsigned CFG_EXT0_POL = 0;
   localparam int unsigned CFG_EXT1_POL = 1;
   localparam int unsigned CFG_T0_GATE = 2;

   // interrupt status and mask field positions
   localparam int unsigned IRQ_EXT0 = 0;
   localparam int unsigned IRQ_EXT1 = 1;
   localparam int unsigned IRQ_T0 = 2;

   // values after reset
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [2:0] CFG_RST = 3'h0;
   localparam logic [2:0] IRQ_STAT_RST = 3'h0;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;

   // apb request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } eitf_apb_req_t;

   // apb answer to the master
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } eitf_apb_rsp_t;

   // one external input after polarity
   typedef struct packed {
      logic active;
      logic edge_ev;
   } eitf_chan_t;

   // state of one input channel
   typedef struct packed {
      logic active;
   } eitf_chan_state_t;

   // state of the top module
   typedef struct packed {
      logic [7:0] ctrl;
      logic [2:0] cfg;
      logic [2:0] irq_status;
      logic [2:0] irq_mask;
      logic irq;
      logic t0_count_en;
      eitf_apb_rsp_t rsp;
   } eitf_state_t;

endpackage : eitf_pkg

// file: eitf_top.sv
// eitf_top: timer 0 flag, run bit and two external interrupt flags behind an APB slave.
// assumes inputs synchronous to ref_clk_i and one-cycle vectoring pulses from the CPU.
// Notes on behaviour
// [R01] The interrupt 1 flag is set by an edge or a level on its input, as its type bit selects.
// [R02] In level mode the interrupt 1 flag is forced to one while its input is active.
// [R03] The interrupt 0 flag is set by an edge or a level on its input, as its type bit selects.
// [R04] In level mode the interrupt 0 flag is forced to one while its input is active.
// [R05] In edge mode each external flag clears itself when the CPU vectors to its handler.
// [R06] Software clears either external flag by writing zero to it, in either mode.
// [R07] The interrupt 1 type bit picks level (0) or edge (1), with polarity from its own bit.
// [R08] The interrupt 0 type bit picks level (0) or edge (1), with polarity from its own bit.
// [R09] The timer 0 overflow flag at bit 5 is set when the timer 0 counter overflows.
// [R10] The run bit at bit 4 enables counting when gate control is zero or interrupt 0 is active.
// [R11] The timer 0 overflow flag clears on vectoring to its handler and may be cleared by software.
`timescale 1ns/1ps
module eitf_top
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // register bus
   input eitf_pkg::eitf_apb_req_t apb_req_i,
   output eitf_pkg::eitf_apb_rsp_t apb_rsp_o,
   // external inputs and timer event
   input wire logic ext0_input_i,
   input wire logic ext1_input_i,
   input wire logic t0_overflow_i,
   // cpu vectoring acknowledges
   input wire logic vec_ext0_i,
   input wire logic vec_ext1_i,
   input wire logic vec_t0_i,
   // flags and enables toward cpu and timer
   output logic ext0_pending_flag_o,
   output logic ext1_pending_flag_o,
   output logic t0_overflow_flag_o,
   output logic t0_count_en_o,
   output logic irq_o
);

   eitf_pkg::eitf_state_t st_q;
   eitf_pkg::eitf_state_t st_d;
   eitf_pkg::eitf_chan_t ch0;
   eitf_pkg::eitf_chan_t ch1;
   logic setup;
   logic access;
   logic wr_ctrl;
   logic wr_stat;
   logic wr_mask;
   logic wr_cfg;

   // next flag value; the set always wins over any clear in the same cycle
   function automatic logic flag_next(input logic is_edge, input logic flag, input logic active,
                                      input logic edge_ev, input logic vec, input logic sw_clr);
      if (is_edge)
      begin
         flag_next = edge_ev | (flag & ~(vec | sw_clr));
      end
      else
      begin
         flag_next = active | (flag & ~sw_clr);
      end
   endfunction : flag_next

   // read data mux; unmapped addresses read zero
   function automatic logic [31:0] rd_mux(input logic [7:0] addr, input eitf_pkg::eitf_state_t s);
      unique case (addr)
         eitf_pkg::CTRL_OFS: rd_mux = {24'h000000, s.ctrl};
         eitf_pkg::CFG_OFS: rd_mux = {29'h00000000, s.cfg};
         eitf_pkg::IRQ_STAT_OFS: rd_mux = {29'h00000000, s.irq_status};
         eitf_pkg::IRQ_MASK_OFS: rd_mux = {29'h00000000, s.irq_mask};
         default: rd_mux = 32'h00000000;
      endcase
   endfunction : rd_mux

   function automatic logic addr_hit(input logic [7:0] addr);
      addr_hit = (addr == eitf_pkg::CTRL_OFS) || (addr == eitf_pkg::CFG_OFS) ||
                 (addr == eitf_pkg::IRQ_STAT_OFS) || (addr == eitf_pkg::IRQ_MASK_OFS);
   endfunction : addr_hit

   // input channels with polarity from the configuration register
   eitf_ext_chan u_chan0
   (
      .ref_clk_i (ref_clk_i),
      .rst_i (rst_i),
      .pin_i (ext0_input_i),
      .polarity_i (st_q.cfg[eitf_pkg::CFG_EXT0_POL]),
      .chan_o (ch0)
   );

   eitf_ext_chan u_chan1
   (
      .ref_clk_i (ref_clk_i),
      .rst_i (rst_i),
      .pin_i (ext1_input_i),
      .polarity_i (st_q.cfg[eitf_pkg::CFG_EXT1_POL]),
      .chan_o (ch1)
   );

   // apb phase decode; no wait state, pready registered from setup so read data can come from a flop
   assign setup = apb_req_i.psel & ~apb_req_i.penable;
   assign access = apb_req_i.psel & apb_req_i.penable & st_q.rsp.pready;
   assign wr_ctrl = access & apb_req_i.pwrite & (apb_req_i.paddr == eitf_pkg::CTRL_OFS);
   assign wr_cfg = access & apb_req_i.pwrite & (apb_req_i.paddr == eitf_pkg::CFG_OFS);
   assign wr_stat = access & apb_req_i.pwrite & (apb_req_i.paddr == eitf_pkg::IRQ_STAT_OFS);
   assign wr_mask = access & apb_req_i.pwrite & (apb_req_i.paddr == eitf_pkg::IRQ_MASK_OFS);

   // next state
   always_comb
   begin
      st_d = st_q;
      // type and run bits are plain software bits
      if (wr_ctrl)
      begin
         st_d.ctrl[eitf_pkg::CTRL_EXT1_TYPE] = apb_req_i.pwdata[eitf_pkg::CTRL_EXT1_TYPE]; // see [R07]
         st_d.ctrl[eitf_pkg::CTRL_EXT0_TYPE] = apb_req_i.pwdata[eitf_pkg::CTRL_EXT0_TYPE]; // see [R08]
         st_d.ctrl[eitf_pkg::CTRL_T0_RUN] = apb_req_i.pwdata[eitf_pkg::CTRL_T0_RUN];
      end
      if (wr_cfg)
      begin
         st_d.cfg = apb_req_i.pwdata[2:0];
      end
      // external flags; writing one to a flag bit is ignored
      st_d.ctrl[eitf_pkg::CTRL_EXT1_FLAG] = flag_next(st_q.ctrl[eitf_pkg::CTRL_EXT1_TYPE], // see [R01] [R02] [R07]
         st_q.ctrl[eitf_pkg::CTRL_EXT1_FLAG], ch1.active, ch1.edge_ev, vec_ext1_i, // see [R05]
         wr_ctrl & ~apb_req_i.pwdata[eitf_pkg::CTRL_EXT1_FLAG]); // see [R06]
      st_d.ctrl[eitf_pkg::CTRL_EXT0_FLAG] = flag_next(st_q.ctrl[eitf_pkg::CTRL_EXT0_TYPE], // see [R03] [R04] [R08]
         st_q.ctrl[eitf_pkg::CTRL_EXT0_FLAG], ch0.active, ch0.edge_ev, vec_ext0_i, // see [R05]
         wr_ctrl & ~apb_req_i.pwdata[eitf_pkg::CTRL_EXT0_FLAG]); // see [R06]
      // timer 0 overflow flag, overflow wins over clears
      st_d.ctrl[eitf_pkg::CTRL_T0_OVF] = t0_overflow_i | // see [R09]
         (st_q.ctrl[eitf_pkg::CTRL_T0_OVF] & ~(vec_t0_i | (wr_ctrl & ~apb_req_i.pwdata[eitf_pkg::CTRL_T0_OVF]))); // see [R11]
      // sticky events: rising of each external flag or a timer 0 overflow, write one to clear, set wins
      st_d.irq_status[eitf_pkg::IRQ_EXT0] = (st_d.ctrl[eitf_pkg::CTRL_EXT0_FLAG] & ~st_q.ctrl[eitf_pkg::CTRL_EXT0_FLAG]) |
         (st_q.irq_status[eitf_pkg::IRQ_EXT0] & ~(wr_stat & apb_req_i.pwdata[eitf_pkg::IRQ_EXT0]));
      st_d.irq_status[eitf_pkg::IRQ_EXT1] = (st_d.ctrl[eitf_pkg::CTRL_EXT1_FLAG] & ~st_q.ctrl[eitf_pkg::CTRL_EXT1_FLAG]) |
         (st_q.irq_status[eitf_pkg::IRQ_EXT1] & ~(wr_stat & apb_req_i.pwdata[eitf_pkg::IRQ_EXT1]));
      st_d.irq_status[eitf_pkg::IRQ_T0] = t0_overflow_i |
         (st_q.irq_status[eitf_pkg::IRQ_T0] & ~(wr_stat & apb_req_i.pwdata[eitf_pkg::IRQ_T0]));
      if (wr_mask)
      begin
         st_d.irq_mask = apb_req_i.pwdata[2:0];
      end
      st_d.irq = |(st_d.irq_status & st_d.irq_mask);
      // gate uses the interrupt 0 level after polarity, as the timer does
      st_d.t0_count_en = st_q.ctrl[eitf_pkg::CTRL_T0_RUN] &
         (~st_q.cfg[eitf_pkg::CFG_T0_GATE] | ch0.active); // see [R10]
      // apb answer: ready in the access cycle, data latched at setup
      st_d.rsp.pready = setup;
      st_d.rsp.pslverr = setup & ~addr_hit(apb_req_i.paddr);
      if (setup)
      begin
         st_d.rsp.prdata = rd_mux(apb_req_i.paddr, st_q);
      end
   end

   // state register
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
      begin
         st_q.ctrl <= eitf_pkg::CTRL_RST;
         st_q.cfg <= eitf_pkg::CFG_RST;
         st_q.irq_status <= eitf_pkg::IRQ_STAT_RST;
         st_q.irq_mask <= eitf_pkg::IRQ_MASK_RST;
         st_q.irq <= 1'b0;
         st_q.t0_count_en <= 1'b0;
         st_q.rsp <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs straight from the state flops
   assign apb_rsp_o = st_q.rsp;
   assign ext0_pending_flag_o = st_q.ctrl[eitf_pkg::CTRL_EXT0_FLAG];
   assign ext1_pending_flag_o = st_q.ctrl[eitf_pkg::CTRL_EXT1_FLAG];
   assign t0_overflow_flag_o = st_q.ctrl[eitf_pkg::CTRL_T0_OVF];
   assign t0_count_en_o = st_q.t0_count_en;
   assign irq_o = st_q.irq;

   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   edge1_set_a: assert property (st_q.ctrl[eitf_pkg::CTRL_EXT1_TYPE] && ch1.edge_ev |=> ext1_pending_flag_o) // see [R01]
      else $error("edge on input 1 did not set its flag");
   level1_hold_a: assert property (!st_q.ctrl[eitf_pkg::CTRL_EXT1_TYPE] && ch1.active |=> ext1_pending_flag_o) // see [R02]
      else $error("level on input 1 did not hold its flag");
   edge0_set_a: assert property (st_q.ctrl[eitf_pkg::CTRL_EXT0_TYPE] && ch0.edge_ev |=> ext0_pending_flag_o) // see [R03]
      else $error("edge on input 0 did not set its flag");
   level0_hold_a: assert property (!st_q.ctrl[eitf_pkg::CTRL_EXT0_TYPE] && ch0.active |=> ext0_pending_flag_o) // see [R04]
      else $error("level on input 0 did not hold its flag");
   vector_clear_a: assert property (st_q.ctrl[eitf_pkg::CTRL_EXT1_TYPE] && vec_ext1_i && !ch1.edge_ev // see [R05]
      |=> !ext1_pending_flag_o)
      else $error("vectoring did not clear edge flag 1");
   soft_clear_a: assert property (wr_ctrl && !apb_req_i.pwdata[eitf_pkg::CTRL_EXT0_FLAG] && // see [R06]
      !(st_q.ctrl[eitf_pkg::CTRL_EXT0_TYPE] ? ch0.edge_ev : ch0.active) |=> !ext0_pending_flag_o)
      else $error("software write did not clear flag 0");
   type_write_a: assert property (wr_ctrl |=> st_q.ctrl[eitf_pkg::CTRL_EXT1_TYPE] == // see [R07]
      $past(apb_req_i.pwdata[eitf_pkg::CTRL_EXT1_TYPE]) && st_q.ctrl[eitf_pkg::CTRL_EXT0_TYPE] == // see [R08]
      $past(apb_req_i.pwdata[eitf_pkg::CTRL_EXT0_TYPE]))
      else $error("type bits not written");
   overflow_set_a: assert property (t0_overflow_i |=> t0_overflow_flag_o && // see [R09]
      (irq_o || !st_q.irq_mask[eitf_pkg::IRQ_T0]))
      else $error("overflow did not set flag or irq");
   run_gate_a: assert property (##1 t0_count_en_o == $past(st_q.ctrl[eitf_pkg::CTRL_T0_RUN] && // see [R10]
      (!st_q.cfg[eitf_pkg::CFG_T0_GATE] || ch0.active)))
      else $error("count enable does not follow run and gate");
   overflow_clear_a: assert property (vec_t0_i && !t0_overflow_i |=> !t0_overflow_flag_o) // see [R11]
      else $error("vectoring did not clear overflow flag");
   apb_ready_a: assert property (setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready)
      else $error("apb ready not one cycle after setup");

   edge_mode_c: cover property (st_q.ctrl[eitf_pkg::CTRL_EXT0_TYPE] && ch0.edge_ev ##1 vec_ext0_i);
   level_mode_c: cover property (!st_q.ctrl[eitf_pkg::CTRL_EXT1_TYPE] && ch1.active ##1 ext1_pending_flag_o);
   irq_raise_c: cover property (!irq_o ##1 irq_o);
   gated_run_c: cover property (st_q.cfg[eitf_pkg::CFG_T0_GATE] && t0_count_en_o);

endmodule : eitf_top
